/* File: design/dsw_pkg.sv */
// package: constants for the dll-off to dll-on switch sequencer
package dsw_pkg;
    // ********************************************************************
    // clocks and timing
    // ********************************************************************
    localparam int unsigned CLK_PERIOD_PS  = 25000;
    // link clock half period in host clocks (link period = 2*div*25 ns)
    localparam logic [3:0]  LINK_DIV       = 4'h1;
    // timing defaults, in link clock cycles (nCK), software may reprogram
    localparam logic [15:0] T_CKSRE_RST    = 16'h000a;
    localparam logic [15:0] T_CKSRX_RST    = 16'h000a;
    localparam logic [15:0] T_XS_RST       = 16'h0080;
    localparam logic [15:0] T_MRD_RST      = 16'h0004;
    localparam logic [15:0] T_MOD_RST      = 16'h000c;
    localparam logic [15:0] T_DLLK_RST     = 16'h0200;
    localparam logic [15:0] T_ZQOPER_RST   = 16'h0200;

    // ********************************************************************
    // wishbone register map (byte addresses)
    // ********************************************************************
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_TCKSRE     = 8'h08;
    localparam logic [7:0]  REG_TCKSRX     = 8'h0c;
    localparam logic [7:0]  REG_TXS        = 8'h10;
    localparam logic [7:0]  REG_TMRD       = 8'h14;
    localparam logic [7:0]  REG_TMOD       = 8'h18;
    localparam logic [7:0]  REG_TDLLK      = 8'h1c;
    localparam logic [7:0]  REG_TZQOPER    = 8'h20;
    localparam logic [7:0]  REG_MR0        = 8'h24;
    localparam logic [7:0]  REG_MR1        = 8'h28;
    localparam logic [7:0]  REG_MR2        = 8'h2c;

    // ctrl fields
    localparam int unsigned CTRL_START     = 0;
    localparam int unsigned CTRL_ZQCL      = 1;
    localparam int unsigned CTRL_ODT_EN    = 2;
    // status fields
    localparam int unsigned STAT_BUSY      = 0;
    localparam int unsigned STAT_DONE      = 1;

    // mode register bits that the sequence touches
    localparam int unsigned MR1_DLL_DIS    = 0;
    localparam int unsigned MR0_DLL_RST    = 8;

    // ********************************************************************
    // command encodings {cs_n, ras_n, cas_n, we_n}
    // ********************************************************************
    localparam logic [3:0]  CMD_NOP        = 4'h7;
    localparam logic [3:0]  CMD_MRS        = 4'h0;
    localparam logic [3:0]  CMD_REF        = 4'h1;
    localparam logic [3:0]  CMD_ZQ         = 4'h6;
    localparam logic [3:0]  CMD_DES        = 4'h8;

    typedef enum logic [3:0] {
        DSW_IDLE,
        DSW_SRE,
        DSW_CKSRE,
        DSW_FREQ,
        DSW_CKSRX,
        DSW_SRX,
        DSW_XS,
        DSW_MR1,
        DSW_MR0,
        DSW_MR2,
        DSW_MR0F,
        DSW_ZQ,
        DSW_FINAL,
        DSW_DONE
    } dsw_state_t;
endpackage : dsw_pkg

/* File: design/dsw_switch.sv */
// host sequencer that moves a ddr3 dram from dll-off to dll-on operation
//
// Operation
// - start only from idle, banks precharged, odt off, before self refresh
// - enter self refresh and wait tCKSRE before changing clock rate
// - provide a stable new clock for tCKSRX before self refresh exit
// - cke held high from exit until tDLLK after the dll reset
// - termination enabled at entry: odt held low until tDLLK passes
// - termination disabled at entry: odt may be low or high
// - after tXS write mr1 with a0 cleared to enable the dll
// - after tMRD write mr0 with a8 set to reset the dll
// - after another tMRD write mode registers for the new rate
// - long zq calibration allowed once tMOD passed after last mrs
// - wait tMOD after the final mrs before ordinary commands
// - no dll-dependent command until tDLLK after the dll reset
// - if long zq was issued also wait tZQoper
// - cycle counts are counted in actual link clock edges
// - nanosecond figures become cycles by dividing and rounding up
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module dsw_switch (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        link_clk_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             ck_o,
    output logic             ck_n_o,
    output logic             cke_o,
    output logic             odt_o,
    output logic             cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic      [2:0]  ba_o,
    output logic      [15:0] addr_o
);
    // ********************************************************************
    // register file
    // ********************************************************************
    logic [15:0] t_cksre_r, t_cksrx_r, t_xs_r, t_mrd_r, t_mod_r;
    logic [15:0] t_dllk_r, t_zqoper_r, mr0_r, mr1_r, mr2_r;
    logic        zqcl_r, odt_en_r, start_tgl_r;
    logic        busy_s2_r, busy_s1_r, done_s2_r, done_s1_r;
    logic        busy_seq_r, done_seq_r, ack_s1_r, ack_s2_r;
    logic [7:0]  wb_wadr;
    logic        wb_hit;

    assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wadr = wb_adr_i;

    // ack one cycle after the request, dropped the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_cksre_r   <= dsw_pkg::T_CKSRE_RST;
            t_cksrx_r   <= dsw_pkg::T_CKSRX_RST;
            t_xs_r      <= dsw_pkg::T_XS_RST;
            t_mrd_r     <= dsw_pkg::T_MRD_RST;
            t_mod_r     <= dsw_pkg::T_MOD_RST;
            t_dllk_r    <= dsw_pkg::T_DLLK_RST;
            t_zqoper_r  <= dsw_pkg::T_ZQOPER_RST;
            mr0_r       <= 16'h0000;
            mr1_r       <= 16'h0001;
            mr2_r       <= 16'h0000;
            zqcl_r      <= 1'b0;
            odt_en_r    <= 1'b0;
            start_tgl_r <= 1'b0;
        end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
            // timing and mode values only change while idle
            if (!busy_seq_r) begin
                case (wb_wadr)
                    dsw_pkg::REG_CTRL: begin
                        zqcl_r   <= wb_dat_i[dsw_pkg::CTRL_ZQCL];
                        odt_en_r <= wb_dat_i[dsw_pkg::CTRL_ODT_EN];
                        if (wb_dat_i[dsw_pkg::CTRL_START]) begin
                            start_tgl_r <= ~start_tgl_r;
                        end
                    end
                    dsw_pkg::REG_TCKSRE:  t_cksre_r  <= wb_dat_i[15:0];
                    dsw_pkg::REG_TCKSRX:  t_cksrx_r  <= wb_dat_i[15:0];
                    dsw_pkg::REG_TXS:     t_xs_r     <= wb_dat_i[15:0];
                    dsw_pkg::REG_TMRD:    t_mrd_r    <= wb_dat_i[15:0];
                    dsw_pkg::REG_TMOD:    t_mod_r    <= wb_dat_i[15:0];
                    dsw_pkg::REG_TDLLK:   t_dllk_r   <= wb_dat_i[15:0];
                    dsw_pkg::REG_TZQOPER: t_zqoper_r <= wb_dat_i[15:0];
                    dsw_pkg::REG_MR0:     mr0_r      <= wb_dat_i[15:0];
                    dsw_pkg::REG_MR1:     mr1_r      <= wb_dat_i[15:0];
                    dsw_pkg::REG_MR2:     mr2_r      <= wb_dat_i[15:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_hit && !wb_we_i) begin
            case (wb_wadr)
                dsw_pkg::REG_CTRL:    wb_dat_o <= {29'h0, odt_en_r,
                                                   zqcl_r, 1'b0};
                dsw_pkg::REG_STATUS:  wb_dat_o <= {30'h0, done_seq_r,
                                                   busy_seq_r};
                dsw_pkg::REG_TCKSRE:  wb_dat_o <= {16'h0, t_cksre_r};
                dsw_pkg::REG_TCKSRX:  wb_dat_o <= {16'h0, t_cksrx_r};
                dsw_pkg::REG_TXS:     wb_dat_o <= {16'h0, t_xs_r};
                dsw_pkg::REG_TMRD:    wb_dat_o <= {16'h0, t_mrd_r};
                dsw_pkg::REG_TMOD:    wb_dat_o <= {16'h0, t_mod_r};
                dsw_pkg::REG_TDLLK:   wb_dat_o <= {16'h0, t_dllk_r};
                dsw_pkg::REG_TZQOPER: wb_dat_o <= {16'h0, t_zqoper_r};
                dsw_pkg::REG_MR0:     wb_dat_o <= {16'h0, mr0_r};
                dsw_pkg::REG_MR1:     wb_dat_o <= {16'h0, mr1_r};
                dsw_pkg::REG_MR2:     wb_dat_o <= {16'h0, mr2_r};
                default:              wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************************************************
    // status back from the link domain, two-flop synchronisers
    // ********************************************************************
    logic busy_lk_r, done_lk_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_s1_r  <= 1'b0;
            busy_s2_r  <= 1'b0;
            done_s1_r  <= 1'b0;
            done_s2_r  <= 1'b0;
            busy_seq_r <= 1'b0;
            done_seq_r <= 1'b0;
        end else begin
            busy_s1_r  <= busy_lk_r;
            busy_s2_r  <= busy_s1_r;
            done_s1_r  <= done_lk_r;
            done_s2_r  <= done_s1_r;
            // busy also covers the start toggle still in flight
            busy_seq_r <= busy_s2_r || (start_tgl_r != ack_s2_r);
            done_seq_r <= done_s2_r;
        end
    end

    // ********************************************************************
    // dram clock: half the link clock rate, toggled on every link clock rising edge
    // ********************************************************************
    // the frequency change is modelled by the bench changing link_clk_i;
    // the sequence spends one link cycle in DSW_FREQ, then goes on to DSW_CKSRX
    logic ck_run_r;

    always_ff @(posedge link_clk_i) begin
        ck_o   <= ck_run_r;
        ck_n_o <= ~ck_run_r;
    end

    // ********************************************************************
    // link domain sequencer
    // ********************************************************************
    logic                 st_s1_r, st_s2_r, st_seen_r;
    dsw_pkg::dsw_state_t  state_r;
    logic [15:0]          wait_r, dllk_r, zq_r;
    logic                 rst_lk_s1_r, rst_lk_r;
    logic                 start_req;

    always_ff @(posedge link_clk_i) begin
        rst_lk_s1_r <= rst_i;
        rst_lk_r    <= rst_lk_s1_r;
        st_s1_r     <= start_tgl_r;
        st_s2_r     <= st_s1_r;
    end

    // ack toggle back to host domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= st_seen_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    assign start_req = (st_s2_r != st_seen_r);

    // one mrs or other command on the pins for one link cycle
    function automatic logic [3:0] cmd_of(input dsw_pkg::dsw_state_t s);
        case (s)
            dsw_pkg::DSW_SRE:   cmd_of = dsw_pkg::CMD_REF;
            dsw_pkg::DSW_MR1,
            dsw_pkg::DSW_MR0,
            dsw_pkg::DSW_MR2,
            dsw_pkg::DSW_MR0F:  cmd_of = dsw_pkg::CMD_MRS;
            dsw_pkg::DSW_ZQ:    cmd_of = dsw_pkg::CMD_ZQ;
            default:            cmd_of = dsw_pkg::CMD_NOP;
        endcase
    endfunction : cmd_of

    always_ff @(posedge link_clk_i) begin
        if (rst_lk_r) begin
            state_r   <= dsw_pkg::DSW_IDLE;
            wait_r    <= 16'h0000;
            dllk_r    <= 16'h0000;
            zq_r      <= 16'h0000;
            st_seen_r <= 1'b0;
            busy_lk_r <= 1'b0;
            done_lk_r <= 1'b0;
            ck_run_r  <= 1'b0;
            cke_o     <= 1'b1;
            odt_o     <= 1'b0;
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= dsw_pkg::CMD_NOP;
            ba_o      <= 3'h0;
            addr_o    <= 16'h0000;
        end else begin
            // one pin command on the cycle a command state is left, nop otherwise
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= dsw_pkg::CMD_NOP;
            ck_run_r <= ~ck_run_r;
            if (wait_r != 16'h0000) begin
                wait_r <= wait_r - 16'h0001;
            end
            if (dllk_r != 16'h0000) begin
                dllk_r <= dllk_r - 16'h0001;
            end
            if (zq_r != 16'h0000) begin
                zq_r <= zq_r - 16'h0001;
            end
            // odt never driven high while the switch runs
            odt_o <= 1'b0;
            case (state_r)
                dsw_pkg::DSW_IDLE: begin
                    // software guarantees idle dram before starting
                    if (start_req) begin
                        st_seen_r <= st_s2_r;
                        busy_lk_r <= 1'b1;
                        done_lk_r <= 1'b0;
                        state_r   <= dsw_pkg::DSW_SRE;
                    end
                end
                dsw_pkg::DSW_SRE: begin
                    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd_of(state_r);
                    cke_o   <= 1'b0;
                    wait_r  <= t_cksre_r;
                    state_r <= dsw_pkg::DSW_CKSRE;
                end
                dsw_pkg::DSW_CKSRE: begin
                    if (wait_r == 16'h0000) begin
                        state_r <= dsw_pkg::DSW_FREQ;
                    end
                end
                dsw_pkg::DSW_FREQ: begin
                    // clock may change now; tCKSRX counted on the new clock
                    wait_r  <= t_cksrx_r;
                    state_r <= dsw_pkg::DSW_CKSRX;
                end
                dsw_pkg::DSW_CKSRX: begin
                    if (wait_r == 16'h0000) begin
                        state_r <= dsw_pkg::DSW_SRX;
                    end
                end
                dsw_pkg::DSW_SRX: begin
                    cke_o   <= 1'b1;
                    wait_r  <= t_xs_r;
                    state_r <= dsw_pkg::DSW_XS;
                end
                dsw_pkg::DSW_XS: begin
                    if (wait_r == 16'h0000) begin
                        state_r <= dsw_pkg::DSW_MR1;
                    end
                end
                dsw_pkg::DSW_MR1: begin
                    if (wait_r == 16'h0000) begin
                        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd_of(state_r);
                        ba_o    <= 3'h1;
                        addr_o  <= mr1_r & ~(16'h0001 << dsw_pkg::MR1_DLL_DIS);
                        wait_r  <= t_mrd_r;
                        state_r <= dsw_pkg::DSW_MR0;
                    end
                end
                dsw_pkg::DSW_MR0: begin
                    if (wait_r == 16'h0001) begin
                        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd_of(state_r);
                        ba_o    <= 3'h0;
                        addr_o  <= mr0_r | (16'h0001 << dsw_pkg::MR0_DLL_RST);
                        dllk_r  <= t_dllk_r;
                        wait_r  <= t_mrd_r;
                        state_r <= dsw_pkg::DSW_MR2;
                    end
                end
                dsw_pkg::DSW_MR2: begin
                    if (wait_r == 16'h0001) begin
                        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd_of(state_r);
                        ba_o    <= 3'h2;
                        addr_o  <= mr2_r;
                        wait_r  <= t_mrd_r;
                        state_r <= dsw_pkg::DSW_MR0F;
                    end
                end
                dsw_pkg::DSW_MR0F: begin
                    if (wait_r == 16'h0001) begin
                        // new cl/wr without another dll reset
                        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd_of(state_r);
                        ba_o    <= 3'h0;
                        addr_o  <= mr0_r & ~(16'h0001 << dsw_pkg::MR0_DLL_RST);
                        wait_r  <= t_mod_r;
                        state_r <= zqcl_r ? dsw_pkg::DSW_ZQ
                                          : dsw_pkg::DSW_FINAL;
                    end
                end
                dsw_pkg::DSW_ZQ: begin
                    if (wait_r == 16'h0001) begin
                        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd_of(state_r);
                        addr_o  <= 16'h0400;
                        zq_r    <= t_zqoper_r;
                        state_r <= dsw_pkg::DSW_FINAL;
                    end
                end
                dsw_pkg::DSW_FINAL: begin
                    // all three waits must be over
                    if (wait_r == 16'h0000 && dllk_r == 16'h0000 &&
                        zq_r == 16'h0000) begin
                        busy_lk_r <= 1'b0;
                        done_lk_r <= 1'b1;
                        state_r   <= dsw_pkg::DSW_DONE;
                    end
                end
                dsw_pkg::DSW_DONE: begin
                    state_r <= dsw_pkg::DSW_IDLE;
                end
                default: begin
                    state_r <= dsw_pkg::DSW_IDLE;
                end
            endcase
        end
    end
endmodule : dsw_switch

/* File: bench/dsw_switch_props.sv */
// pin-level checks for the dll switch sequencer
`timescale 1ns/10ps
module dsw_switch_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cke_o,
    input wire logic odt_o,
    input wire logic cs_n_o,
    input wire logic ras_n_o,
    input wire logic cas_n_o,
    input wire logic we_n_o
);
    logic [3:0] cmd;
    logic       mrs;
    logic       zq;
    assign cmd = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
    assign mrs = cmd == dsw_pkg::CMD_MRS;
    assign zq  = cmd == dsw_pkg::CMD_ZQ;
    // ****
    // checks
    // ****
    chk_ack_once:
    assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ack_answer:
    assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    chk_odt_low:
    assert property (@(posedge link_clk_i) disable iff (rst_i)
        !odt_o) else $error("odt high");
    chk_sre_hold:
    assert property (@(posedge link_clk_i) disable iff (rst_i)
        $fell(cke_o) |-> (cmd == dsw_pkg::CMD_REF) ##1 !cke_o [*7])
        else $error("self refresh too short");
    chk_srx_hold:
    assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(cke_o) |-> cke_o [*8]) else $error("cke dropped");
    chk_mrs_space:
    assert property (@(posedge link_clk_i) disable iff (rst_i)
        mrs |=> !mrs [*3]) else $error("mrs too close");
    chk_xs_wait:
    assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(cke_o) |-> !mrs [*4]) else $error("mrs before exit wait");
    chk_zq_wait:
    assert property (@(posedge link_clk_i) disable iff (rst_i)
        mrs |=> !zq [*3]) else $error("zq too soon");
    cov_sre: cover property (@(posedge link_clk_i) $fell(cke_o));
    cov_mrs: cover property (@(posedge link_clk_i) mrs);
    cov_zq: cover property (@(posedge link_clk_i) zq);
endmodule : dsw_switch_chk

bind dsw_switch dsw_switch_chk u_chk (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .link_clk_i (link_clk_i),
    .wb_cyc_i   (wb_cyc_i),
    .wb_stb_i   (wb_stb_i),
    .wb_ack_o   (wb_ack_o),
    .cke_o      (cke_o),
    .odt_o      (odt_o),
    .cs_n_o     (cs_n_o),
    .ras_n_o    (ras_n_o),
    .cas_n_o    (cas_n_o),
    .we_n_o     (we_n_o)
);

/* File: bench/dsw_dram_model.sv */
// behavioural dram: mode registers, dll state and self refresh timing
`timescale 1ns/10ps
module dsw_dram_model #(
    parameter logic [15:0] T_SR  = 16'h0008,
    parameter logic [15:0] T_XS  = 16'h0004,
    parameter logic [15:0] T_MRD = 16'h0004,
    parameter logic [15:0] T_MOD = 16'h0004
) (
    input  wire logic        link_clk_i,
    input  wire logic        rst_i,
    input  wire logic        cke_i,
    input  wire logic        odt_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [2:0]  ba_i,
    input  wire logic [15:0] addr_i,
    output logic      [7:0]  err_o,
    output logic             dll_on_o,
    output logic      [3:0]  mrs_cnt_o,
    output logic             zq_o,
    output logic      [15:0] dllk_cnt_o,
    output logic      [15:0] mr0_o
);
    logic [3:0]  cmd;
    logic        sr_r;
    logic [15:0] sr_cnt_r;
    logic [15:0] xs_cnt_r;
    logic [15:0] mrd_cnt_r;
    assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    // saturating, so a long idle never wraps into a false short gap
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : inc
    always_ff @(posedge link_clk_i) begin
        if (rst_i) begin
            sr_r       <= 1'b0;
            {sr_cnt_r, xs_cnt_r, mrd_cnt_r, dllk_cnt_o} <= '1;
            err_o      <= 8'h00;
            dll_on_o   <= 1'b0;
            mrs_cnt_o  <= 4'h0;
            zq_o       <= 1'b0;
            mr0_o      <= 16'h0000;
        end else begin
            sr_cnt_r   <= inc(sr_cnt_r);
            xs_cnt_r   <= inc(xs_cnt_r);
            mrd_cnt_r  <= inc(mrd_cnt_r);
            dllk_cnt_o <= inc(dllk_cnt_o);
            if (odt_i)
                err_o <= err_o + 8'h01;
            if (cmd == dsw_pkg::CMD_REF && !cke_i && !sr_r) begin
                sr_r      <= 1'b1;
                sr_cnt_r  <= 16'h0001;
                mrs_cnt_o <= 4'h0;
                zq_o      <= 1'b0;
            end else if (sr_r && cke_i) begin
                sr_r     <= 1'b0;
                xs_cnt_r <= 16'h0001;
                if (sr_cnt_r < T_SR)
                    err_o <= err_o + 8'h01;
            end else if (!sr_r && !cke_i)
                err_o <= err_o + 8'h01;
            if (sr_r && !cs_n_i && cmd != dsw_pkg::CMD_NOP)
                err_o <= err_o + 8'h01;
            if (cke_i && cmd == dsw_pkg::CMD_MRS) begin
                mrs_cnt_o <= mrs_cnt_o + 4'h1;
                mrd_cnt_r <= 16'h0001;
                if (mrd_cnt_r < T_MRD || xs_cnt_r < T_XS)
                    err_o <= err_o + 8'h01;
                if (ba_i == 3'h1)
                    dll_on_o <= !addr_i[0];
                if (ba_i == 3'h0) begin
                    mr0_o <= addr_i;
                    if (addr_i[8])
                        dllk_cnt_o <= 16'h0001;
                    if (addr_i[8] && !dll_on_o)
                        err_o <= err_o + 8'h01;
                end
            end
            if (cke_i && cmd == dsw_pkg::CMD_ZQ) begin
                zq_o <= 1'b1;
                if (mrd_cnt_r < T_MOD || !dll_on_o)
                    err_o <= err_o + 8'h01;
            end
        end
    end
endmodule : dsw_dram_model

/* File: bench/test_dsw_switch.sv */
// self-checking bench for the dll switch sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_dsw_switch;
    localparam logic [15:0] TXS = 16'((230 + 63) / 64);
    localparam logic [15:0] TV [7] = '{16'h0004, 16'h0004, TXS, 16'h0004,
                                       16'h0004, 16'h0028, 16'h0004};
    localparam logic [15:0] DV [7] = '{dsw_pkg::T_CKSRE_RST,
        dsw_pkg::T_CKSRX_RST, dsw_pkg::T_XS_RST, dsw_pkg::T_MRD_RST,
        dsw_pkg::T_MOD_RST, dsw_pkg::T_DLLK_RST, dsw_pkg::T_ZQOPER_RST};
    localparam logic [31:0] MR0V = 32'h0000_0420;
    logic        clk_i = 1'b0;
    logic        link_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, ck_o, ck_n_o, cke_o, odt_o, dll_on, zq_seen;
    logic        cs_n_o, ras_n_o, cas_n_o, we_n_o;
    logic [2:0]  ba_o;
    logic [15:0] addr_o, dllk_cnt, mr0;
    logic [7:0]  merr;
    logic [3:0]  mrs_cnt;
    int          n_errors = 0, compares = 0;
    realtime     lhalf = 40.0;
    always #12.5 clk_i = ~clk_i;
    always #(lhalf) link_clk_i = ~link_clk_i;
    // new rate only once the dram no longer watches its clock
    always @(negedge cke_o) if (!rst_i) begin
        repeat (5) @(posedge link_clk_i);
        lhalf = 32.0;
    end
    dsw_switch dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ck_o(ck_o),
        .ck_n_o(ck_n_o), .cke_o(cke_o), .odt_o(odt_o), .cs_n_o(cs_n_o),
        .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
        .ba_o(ba_o), .addr_o(addr_o));
    dsw_dram_model #(.T_XS(TXS)) u_dram (.link_clk_i(link_clk_i),
        .rst_i(rst_i), .cke_i(cke_o), .odt_i(odt_o), .cs_n_i(cs_n_o),
        .ras_n_i(ras_n_o), .cas_n_i(cas_n_o), .we_n_i(we_n_o),
        .ba_i(ba_o), .addr_i(addr_o), .err_o(merr), .dll_on_o(dll_on),
        .mrs_cnt_o(mrs_cnt), .zq_o(zq_seen), .dllk_cnt_o(dllk_cnt),
        .mr0_o(mr0));
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(a, 1'b0, 32'h0, q);
    endtask : rd
    task automatic poll(input int b, input logic v, output logic [31:0] q);
        repeat (3000) begin
            rd(dsw_pkg::REG_STATUS, q);
            if (q[b] === v) break;
        end
    endtask : poll
    task automatic run_seq(input logic zq_en);
        logic [31:0] q;
        wr(dsw_pkg::REG_CTRL, {29'h0, 1'b0, zq_en, 1'b1});
        poll(dsw_pkg::STAT_BUSY, 1'b1, q);
        `CHK("busy", 1'b1, q[dsw_pkg::STAT_BUSY])
        wr(dsw_pkg::REG_TMRD, 32'h9);
        // done from the last run stands until the link sees the start
        poll(dsw_pkg::STAT_BUSY, 1'b0, q);
        `CHK("done", 2'b10, q[1:0])
        rd(dsw_pkg::REG_TMRD, q);
        `CHK("tmrd_kept", 32'h4, q)
        `CHK("dll_on", 1'b1, dll_on)
        `CHK("mrs_count", 4'h4, mrs_cnt)
        `CHK("mr0_final", MR0V[15:0], mr0)
        `CHK("zq", zq_en, zq_seen)
        `CHK("dllk", 1'b1, dllk_cnt >= TV[5])
        `CHK("dram_err", 8'h00, merr)
        `CHK("ck_pair", ~ck_o, ck_n_o)
    endtask : run_seq
    task automatic summarize;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    initial begin
        logic [31:0] q;
        logic [7:0]  a;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(dsw_pkg::REG_MR1, q);
        `CHK("mr1_reset", 32'h1, q)
        for (int i = 0; i < 7; i++) begin
            a = dsw_pkg::REG_TCKSRE + 8'(4 * i);
            rd(a, q);
            `CHK("t_reset", {16'h0, DV[i]}, q)
            wr(a, {16'h0, TV[i]});
            rd(a, q);
            `CHK("t_prog", {16'h0, TV[i]}, q)
        end
        wr(8'h40, 32'h5a5a_5a5a);
        rd(8'h40, q);
        `CHK("unmapped", 32'h0, q)
        wr(dsw_pkg::REG_MR0, MR0V);
        wr(dsw_pkg::REG_MR2, 32'h18);
        rd(dsw_pkg::REG_MR2, q);
        `CHK("mr2", 32'h18, q)
        run_seq(1'b1);
        run_seq(1'b0);
        summarize();
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        $display("[ERR] watchdog exp finish got timeout");
        summarize();
    end
endmodule : test_dsw_switch
